// *** src/csf_defines.svh ***
// register map, field positions and reset values of the status flag block
`ifndef CSF_DEFINES_SVH
`define CSF_DEFINES_SVH

// byte addresses on the apb bus
`define CSF_ADDR_STATUS   12'h000
`define CSF_ADDR_CORE     12'h004
`define CSF_ADDR_INTCTL   12'h008
`define CSF_ADDR_EVSTAT   12'h00C
`define CSF_ADDR_EVMASK   12'h010
`define CSF_ADDR_PRIO     12'h014

// status word bit positions
`define CSF_B_OA    15
`define CSF_B_OB    14
`define CSF_B_SA    13
`define CSF_B_SB    12
`define CSF_B_OAB   11
`define CSF_B_SAB   10
`define CSF_B_DA    9
`define CSF_B_DC    8
`define CSF_B_IPLH  7
`define CSF_B_IPLL  5
`define CSF_B_RA    4
`define CSF_B_N     3
`define CSF_B_OV    2
`define CSF_B_Z     1
`define CSF_B_C     0

// core control priority extension and interrupt control nesting disable positions
`define CSF_B_PEXT  3
`define CSF_B_NEST  15

// event status bits
`define CSF_EV_SATA 0
`define CSF_EV_SATB 1
`define CSF_EV_OVA  2
`define CSF_EV_OVB  3
`define CSF_EV_W    4

// nibble and byte carry positions
`define CSF_HC_BYTE 4
`define CSF_HC_WORD 8

`define CSF_RST_W16 16'h0000
`define CSF_IPL_TOP 3'h7
`define CSF_NUM_REGS 6
`endif

// *** src/csf_pkg.sv ***
// types shared by the status flag block
package csf_pkg;
    // flag updates from the execution unit, one instruction at a time
    typedef struct packed {
        logic       valid;   // an instruction retires this cycle
        logic       ovf_a;
        logic       ovf_b;
        logic       sat_a;
        logic       sat_b;
        logic       upd_z;   // instruction affects the zero flag
        logic       res_zero;
        logic       upd_alu; // updates n, ov, c, half carry
        logic       is_byte;
        logic       neg;
        logic       ovf;
        logic       carry;
        logic [8:0] carries; // per-bit carry out of the adder
    } csf_exec_t;

    // loop sequencer levels
    typedef struct packed {
        logic block_loop;
        logic rep_loop;
    } csf_loop_t;

    typedef enum logic [1:0] {
        CSF_IDLE,
        CSF_ACCESS
    } csf_apb_st_t;
endpackage

// *** src/csf_prio.sv ***
// priority level former and user interrupt gate
`include "csf_defines.svh"
module csf_prio
    import csf_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] level_bits,
    input  wire logic       level_msb,
    output logic      [3:0] level_r,
    output logic            user_irq_off_r
);
    // registered so the top outputs come from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r        <= 4'h0;
            user_irq_off_r <= 1'b0;
        end else begin
            level_r        <= {level_msb, level_bits};
            // extension bit or top level both mask user sources
            user_irq_off_r <= level_msb
                           || (level_bits == `CSF_IPL_TOP);
        end
    end

    // extension bit masks user sources one cycle later
    property p_ext_off;
        @(posedge pclk) disable iff (!presetn)
        level_msb |=> user_irq_off_r;
    endproperty
    a_ext_off: assert property (p_ext_off)
        else $error("extension bit did not disable user interrupts");

    // top code of the three bits masks user sources as well
    property p_top_off;
        @(posedge pclk) disable iff (!presetn)
        level_bits == `CSF_IPL_TOP |=> user_irq_off_r;
    endproperty
    a_top_off: assert property (p_top_off)
        else $error("top priority level did not disable user interrupts");

    // level is extension bit above the three status bits
    property p_level;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> level_r == $past({level_msb, level_bits});
    endproperty
    a_level: assert property (p_level)
        else $error("priority level wrong");
endmodule

// *** src/csf_top.sv ***
// cpu status word with apb access, event interrupt and priority gate
//
// Contract
// - accumulator a overflow flag follows overflow
// - accumulator b overflow flag follows overflow
// - a saturation flag sticky until software clears
// - b saturation flag sticky until software clears
// - combined overflow is or, clear only
// - combined saturation is or, clear only
// - block loop active flag, read only
// - half carry from bit four or eight
// - priority level adds extension bit as msb
// - extension bit set disables user interrupts
// - priority bits binary, seven disables interrupts
// - priority bits read only when nesting disabled
// - repeat active flag, read only
// - zero flag cleared by nonzero result or by a software write
`include "csf_defines.svh"
module csf_top
    import csf_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire csf_exec_t         exec,
    input  wire csf_loop_t         loops,
    output logic      [15:0]       status_word,
    output logic      [3:0]        cpu_level,
    output logic                   user_irq_off,
    output logic                   irq
);
    // decode slices a 12-bit offset, so wider buses are not served
    if (ADDR_W < 8 || ADDR_W > 12) begin : g_addr_chk
        $error("address width outside what the decode serves");
    end

    logic [15:0] sr_r;
    logic [15:0] core_r;
    logic [15:0] intctl_r;
    logic [4:0]  ev_r;
    logic [4:0]  mask_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        irq_r;
    logic [15:0] sr_nxt;
    csf_apb_st_t st_r;

    // address decode, used by both write and read paths
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [11:0]       o);
        hit = (a[ADDR_W-1:2] == o[ADDR_W-1:2]);
    endfunction

    function automatic logic known(input logic [ADDR_W-1:0] a);
        known = hit(a, `CSF_ADDR_STATUS) || hit(a, `CSF_ADDR_CORE)
             || hit(a, `CSF_ADDR_INTCTL) || hit(a, `CSF_ADDR_EVSTAT)
             || hit(a, `CSF_ADDR_EVMASK) || hit(a, `CSF_ADDR_PRIO);
    endfunction

    // write lands on the access edge; answer comes one cycle after setup
    logic wr_go;
    logic rd_go;
    assign wr_go = psel && penable && pwrite && (st_r == CSF_ACCESS);
    assign rd_go = psel && penable && !pwrite && (st_r == CSF_ACCESS);

    // apb phase tracker: setup then zero-wait access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= CSF_IDLE;
        end else begin
            case (st_r)
                CSF_IDLE:   st_r <= (psel && !penable) ? CSF_ACCESS
                                                       : CSF_IDLE;
                CSF_ACCESS: st_r <= CSF_IDLE;
                default:    st_r <= CSF_IDLE;
            endcase
        end
    end

    // next status word; hardware events win over software writes
    always_comb begin
        logic [15:0] w;
        logic        sa;
        logic        sb;
        w      = pwdata[15:0];
        sr_nxt = sr_r;
        sa     = sr_r[`CSF_B_SA];
        sb     = sr_r[`CSF_B_SB];
        if (wr_go && hit(paddr, `CSF_ADDR_STATUS)) begin
            sr_nxt[`CSF_B_OA] = w[`CSF_B_OA];
            sr_nxt[`CSF_B_OB] = w[`CSF_B_OB];
            // combined bits only clear: zero clears both sources
            if (!w[`CSF_B_OAB]) begin
                sr_nxt[`CSF_B_OA] = 1'b0;
                sr_nxt[`CSF_B_OB] = 1'b0;
            end
            sa = w[`CSF_B_SA];
            sb = w[`CSF_B_SB];
            if (!w[`CSF_B_SAB]) begin
                sa = 1'b0;
                sb = 1'b0;
            end
            sr_nxt[`CSF_B_DC] = w[`CSF_B_DC];
            if (!intctl_r[`CSF_B_NEST]) begin
                sr_nxt[`CSF_B_IPLH:`CSF_B_IPLL] =
                    w[`CSF_B_IPLH:`CSF_B_IPLL];
            end
            sr_nxt[`CSF_B_N]  = w[`CSF_B_N];
            sr_nxt[`CSF_B_OV] = w[`CSF_B_OV];
            sr_nxt[`CSF_B_Z]  = w[`CSF_B_Z];
            sr_nxt[`CSF_B_C]  = w[`CSF_B_C];
        end
        if (exec.valid) begin
            // overflow level tracks the latest accumulator result
            sr_nxt[`CSF_B_OA] = exec.ovf_a;
            sr_nxt[`CSF_B_OB] = exec.ovf_b;
            sa = sa | exec.sat_a;
            sb = sb | exec.sat_b;
            if (exec.upd_z) begin
                // zero flag: nonzero clears, zero sets
                sr_nxt[`CSF_B_Z] = exec.res_zero ? 1'b1 : 1'b0;
            end
            if (exec.upd_alu) begin
                sr_nxt[`CSF_B_DC] = exec.is_byte
                    ? exec.carries[`CSF_HC_BYTE - 1]
                    : exec.carries[`CSF_HC_WORD - 1];
                sr_nxt[`CSF_B_N]  = exec.neg;
                sr_nxt[`CSF_B_OV] = exec.ovf;
                sr_nxt[`CSF_B_C]  = exec.carry;
            end
        end
        sr_nxt[`CSF_B_SA]  = sa;
        sr_nxt[`CSF_B_SB]  = sb;
        // combined bits are derived, so they cannot be set alone
        sr_nxt[`CSF_B_OAB] = sr_nxt[`CSF_B_OA] | sr_nxt[`CSF_B_OB];
        sr_nxt[`CSF_B_SAB] = sa | sb;
        sr_nxt[`CSF_B_DA]  = loops.block_loop;
        sr_nxt[`CSF_B_RA]  = loops.rep_loop;
    end

    // status word register, zero at power-on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_r <= `CSF_RST_W16;
        end else begin
            sr_r <= sr_nxt;
        end
    end

    // core control and interrupt control words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_r   <= `CSF_RST_W16;
            intctl_r <= `CSF_RST_W16;
        end else begin
            if (wr_go && hit(paddr, `CSF_ADDR_CORE)) begin
                core_r <= pwdata[15:0];
            end
            if (wr_go && hit(paddr, `CSF_ADDR_INTCTL)) begin
                intctl_r <= pwdata[15:0];
            end
        end
    end

    // event sticky bits: a set in the clearing cycle wins
    logic [4:0] ev_set;
    assign ev_set = {wr_go && hit(paddr, `CSF_ADDR_STATUS),
                     exec.valid & exec.ovf_b,
                     exec.valid & exec.ovf_a,
                     exec.valid & exec.sat_b & ~sr_r[`CSF_B_SB],
                     exec.valid & exec.sat_a & ~sr_r[`CSF_B_SA]};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_r   <= 5'h0_0;
            mask_r <= 5'h0_0;
        end else begin
            if (wr_go && hit(paddr, `CSF_ADDR_EVSTAT)) begin
                ev_r <= (ev_r & ~pwdata[4:0]) | ev_set;
            end else begin
                ev_r <= ev_r | ev_set;
            end
            if (wr_go && hit(paddr, `CSF_ADDR_EVMASK)) begin
                mask_r <= pwdata[4:0];
            end
        end
    end

    // level interrupt from unmasked sticky events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(ev_r & mask_r);
        end
    end

    // read path and answer; unmapped addresses answer with pslverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel && !penable;
            pslverr_r <= psel && !penable && !known(paddr);
            prdata_r  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                if (hit(paddr, `CSF_ADDR_STATUS))
                    prdata_r <= {16'h0000, sr_r};
                else if (hit(paddr, `CSF_ADDR_CORE))
                    prdata_r <= {16'h0000, core_r};
                else if (hit(paddr, `CSF_ADDR_INTCTL))
                    prdata_r <= {16'h0000, intctl_r};
                else if (hit(paddr, `CSF_ADDR_EVSTAT))
                    prdata_r <= {27'h000_0000, ev_r};
                else if (hit(paddr, `CSF_ADDR_EVMASK))
                    prdata_r <= {27'h000_0000, mask_r};
                else if (hit(paddr, `CSF_ADDR_PRIO))
                    prdata_r <= {27'h000_0000, user_irq_off, cpu_level};
            end
        end
    end

    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign status_word = sr_r;
    assign irq         = irq_r;

    csf_prio u_prio (
        .pclk           (pclk),
        .presetn        (presetn),
        .level_bits     (sr_r[`CSF_B_IPLH:`CSF_B_IPLL]),
        .level_msb      (core_r[`CSF_B_PEXT]),
        .level_r        (cpu_level),
        .user_irq_off_r (user_irq_off)
    );

    // assertions
    property p_ova;
        @(posedge pclk) disable iff (!presetn)
        exec.valid |=> sr_r[`CSF_B_OA] == $past(exec.ovf_a);
    endproperty
    a_ova: assert property (p_ova) else $error("overflow a wrong");

    property p_ovb;
        @(posedge pclk) disable iff (!presetn)
        exec.valid |=> sr_r[`CSF_B_OB] == $past(exec.ovf_b);
    endproperty
    a_ovb: assert property (p_ovb) else $error("overflow b wrong");

    property p_sta;
        @(posedge pclk) disable iff (!presetn)
        sr_r[`CSF_B_SA] && !wr_go |=> sr_r[`CSF_B_SA];
    endproperty
    a_sta: assert property (p_sta) else $error("sat a lost");

    property p_stb;
        @(posedge pclk) disable iff (!presetn)
        exec.valid && exec.sat_b |=> sr_r[`CSF_B_SB];
    endproperty
    a_stb: assert property (p_stb) else $error("sat b not set");

    property p_oab;
        @(posedge pclk) disable iff (!presetn)
        sr_r[`CSF_B_OAB] == (sr_r[`CSF_B_OA] | sr_r[`CSF_B_OB]);
    endproperty
    a_oab: assert property (p_oab) else $error("oab mismatch");

    property p_sab;
        @(posedge pclk) disable iff (!presetn)
        sr_r[`CSF_B_SAB] == (sr_r[`CSF_B_SA] | sr_r[`CSF_B_SB]);
    endproperty
    a_sab: assert property (p_sab) else $error("sab mismatch");

    property p_loops;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> sr_r[`CSF_B_DA] == $past(loops.block_loop)
              && sr_r[`CSF_B_RA] == $past(loops.rep_loop);
    endproperty
    a_loops: assert property (p_loops) else $error("loop flag");

    property p_zero;
        @(posedge pclk) disable iff (!presetn)
        sr_r[`CSF_B_Z] && !(exec.valid && exec.upd_z) && !wr_go
        |=> sr_r[`CSF_B_Z];
    endproperty
    a_zero: assert property (p_zero) else $error("zero cleared");

    property p_ipl;
        @(posedge pclk) disable iff (!presetn)
        intctl_r[`CSF_B_NEST] |=> $stable(sr_r[`CSF_B_IPLH:`CSF_B_IPLL]);
    endproperty
    a_ipl: assert property (p_ipl) else $error("ipl changed");

    // half carry follows the nibble or byte carry of the operand size
    property p_dc;
        @(posedge pclk) disable iff (!presetn)
        exec.valid && exec.upd_alu |=> sr_r[`CSF_B_DC] == $past(
            exec.is_byte ? exec.carries[`CSF_HC_BYTE - 1]
                         : exec.carries[`CSF_HC_WORD - 1]);
    endproperty
    a_dc: assert property (p_dc) else $error("half carry wrong");

    // clearing the combined bit empties both sources, unless a new one
    property p_satclr;
        @(posedge pclk) disable iff (!presetn)
        wr_go && hit(paddr, `CSF_ADDR_STATUS) && !pwdata[`CSF_B_SAB]
            && !(exec.valid && (exec.sat_a || exec.sat_b))
        |=> !sr_r[`CSF_B_SA] && !sr_r[`CSF_B_SB];
    endproperty
    a_satclr: assert property (p_satclr)
        else $error("saturation flags not cleared");

    // every setup cycle is answered in the next cycle
    property p_ans;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready;
    endproperty
    a_ans: assert property (p_ans) else $error("no answer after setup");

    // an unmasked sticky event raises the level interrupt
    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        (ev_r & mask_r) != 5'h00 |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    // a software write to the status word is always recorded
    property p_evw;
        @(posedge pclk) disable iff (!presetn)
        wr_go && hit(paddr, `CSF_ADDR_STATUS) |=> ev_r[`CSF_EV_W];
    endproperty
    a_evw: assert property (p_evw) else $error("write event lost");

    c_sat: cover property (@(posedge pclk) disable iff (!presetn)
        exec.valid && exec.sat_a ##1 sr_r[`CSF_B_SAB]);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
    c_off: cover property (@(posedge pclk) disable iff (!presetn)
        user_irq_off);
endmodule

// *** testbench/tb.sv ***
// self-checking bench of the cpu status flag block
`include "csf_defines.svh"
module tb
    import csf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr;
    logic        user_irq_off, irq, err, nest;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, r;
    csf_exec_t   exec;
    csf_loop_t   loops;
    logic [15:0] status_word, exp_sr;
    logic [3:0]  cpu_level, lv;
    logic [4:0]  exp_ev;
    int          n_mismatch, checks;
    logic [20:0] etbl [13] = '{21'h12_0000, 21'h10_0000, 21'h11_0000,
        21'h18_0000, 21'h10_0000, 21'h14_0000, 21'h10_C000, 21'h10_0000,
        21'h10_8000, 21'h10_3008, 21'h10_3080, 21'h10_2080, 21'h10_2008};
    logic [15:0] wtbl [8] = '{16'h0800, 16'h0400, 16'h3400, 16'h1400,
        16'h3000, 16'hC800, 16'h4000, 16'h010F};

    // 100 mhz core clock
    always #5 pclk = ~pclk;

    csf_top #(.ADDR_W(12)) u_csf_top (
        .pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .exec(exec), .loops(loops),
        .status_word(status_word), .cpu_level(cpu_level),
        .user_irq_off(user_irq_off), .irq(irq)
    );

    // xorshift source, fixed start so runs repeat
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic finish_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // apb master: request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_mismatch++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // status write; combined bits only gate, they never set
    task automatic wsr(input logic [15:0] d);
        apb(1'b1, `CSF_ADDR_STATUS, {16'h0, d});
        exp_sr[15] = d[15] & d[11];
        exp_sr[14] = d[14] & d[11];
        exp_sr[13] = d[13] & d[10];
        exp_sr[12] = d[12] & d[10];
        exp_sr[8] = d[8];
        if (!nest) exp_sr[7:5] = d[7:5];
        exp_sr[3:0] = d[3:0];
        exp_sr[11] = |exp_sr[15:14];
        exp_sr[10] = |exp_sr[13:12];
        exp_ev[4] = 1'b1;
        @(posedge pclk);
        #1;
        chk("status", exp_sr, status_word);
        apb(1'b0, `CSF_ADDR_STATUS, 0);
        chk("status read", exp_sr, rd[15:0]);
        chk("upper", 16'h0, rd[31:16]);
    endtask

    // one retiring instruction, model updated from its flags
    task automatic ex(input logic [20:0] v);
        csf_exec_t e;
        e = csf_exec_t'(v);
        @(posedge pclk);
        exec <= e;
        @(posedge pclk);
        exec.valid <= 1'b0;
        exp_ev |= {1'b0, e.ovf_b, e.ovf_a, e.sat_b & !exp_sr[12],
                   e.sat_a & !exp_sr[13]};
        exp_sr[15] = e.ovf_a;
        exp_sr[14] = e.ovf_b;
        exp_sr[13] |= e.sat_a;
        exp_sr[12] |= e.sat_b;
        if (e.upd_z) exp_sr[1] = e.res_zero;
        if (e.upd_alu) begin
            exp_sr[3] = e.neg;
            exp_sr[2] = e.ovf;
            exp_sr[0] = e.carry;
            exp_sr[8] = e.is_byte ? e.carries[3] : e.carries[7];
        end
        exp_sr[11] = |exp_sr[15:14];
        exp_sr[10] = |exp_sr[13:12];
        #1;
        chk("status", exp_sr, status_word);
    endtask

    // hang guard, far above the real run length
    initial begin
        #1ms;
        n_mismatch++;
        finish_test();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        exec = '0;
        loops = '0;
        seed = 32'h0000_0001;
        nest = 1'b0;
        exp_sr = '0;
        exp_ev = '0;
        n_mismatch = 0;
        checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // every register clears at reset, the hole past them is refused
        for (int a = 0; a < 28; a += 4) begin
            apb(1'b0, 12'(a), 0);
            chk("reset read", 16'h0, rd[15:0]);
            chk("slverr", 16'(a == 24), 16'(err));
        end
        // loop flags follow the sequencer, writes cannot touch them
        loops <= 2'b11;
        exp_sr[9] = 1'b1;
        exp_sr[4] = 1'b1;
        wsr(16'h0000);
        loops <= 2'b00;
        exp_sr[9] = 1'b0;
        exp_sr[4] = 1'b0;
        wsr(16'h0210);
        // sticky saturation, overflow levels, zero and half carry
        foreach (etbl[i]) ex(etbl[i]);
        apb(1'b0, `CSF_ADDR_EVSTAT, 0);
        chk("events", 16'(exp_ev), rd[15:0]);
        foreach (wtbl[i]) wsr(wtbl[i]);
        // every priority code, with and without the extension bit
        for (int v = 0; v < 16; v++) begin
            lv = 4'(v);
            apb(1'b1, `CSF_ADDR_CORE, {28'h0, lv[3], 3'h0});
            wsr({exp_sr[15:8], lv[2:0], exp_sr[4:0]});
            chk("level", 16'(lv), 16'(cpu_level));
            chk("irq off", 16'(lv[3] | &lv[2:0]), 16'(user_irq_off));
            apb(1'b0, `CSF_ADDR_PRIO, 0);
            chk("prio", 16'({lv[3] | &lv[2:0], lv}), rd[15:0]);
        end
        // nesting disable freezes the priority bits
        apb(1'b1, `CSF_ADDR_INTCTL, 32'h0000_8000);
        nest = 1'b1;
        wsr(exp_sr ^ 16'h00E0);
        apb(1'b1, `CSF_ADDR_INTCTL, 0);
        nest = 1'b0;
        // event interrupt: masked, raised, cleared by writing one
        apb(1'b1, `CSF_ADDR_EVMASK, 0);
        apb(1'b1, `CSF_ADDR_EVSTAT, 32'h0000_001F);
        exp_ev = '0;
        wsr(exp_sr);
        ex(21'h18_0000);
        apb(1'b0, `CSF_ADDR_EVSTAT, 0);
        chk("events", 16'(exp_ev), rd[15:0]);
        chk("irq masked", 16'h0, 16'(irq));
        apb(1'b1, `CSF_ADDR_EVMASK, 32'h0000_0010);
        repeat (2) @(posedge pclk);
        #1;
        chk("irq", 16'h1, 16'(irq));
        apb(1'b1, `CSF_ADDR_EVSTAT, 32'h0000_0010);
        repeat (2) @(posedge pclk);
        #1;
        chk("irq cleared", 16'h0, 16'(irq));
        // random instructions with whole-word writes mixed in
        for (int k = 0; k < 80; k++) begin
            r = rnd();
            if (k % 8 == 7) wsr(r[15:0]);
            else ex(r[20:0] | 21'h10_0000);
        end
        // a write to the hole is refused and changes nothing
        apb(1'b1, 12'h018, 32'h0000_FFFF);
        chk("slverr", 16'h1, 16'(err));
        apb(1'b0, `CSF_ADDR_STATUS, 0);
        chk("status read", exp_sr, rd[15:0]);
        finish_test();
    end
endmodule
